// >>> hdl/apm_pkg.sv
// Package of constants and carrier types for the analog pin function mux.
package apm_pkg;

	// Register port geometry.
	localparam int APM_ADDR_W = 8;
	localparam int APM_DATA_W = 32;
	localparam int APM_NUM_PINS = 10;
	localparam int APM_NUM_DIG = 4;

	// Register byte offsets, one aligned word each.
	localparam logic [APM_ADDR_W-1:0] APM_OFS_SELECT = 8'h00;
	localparam logic [APM_ADDR_W-1:0] APM_OFS_DATA = 8'h04;
	localparam logic [APM_ADDR_W-1:0] APM_OFS_DIR = 8'h08;

	// Only odd selection bits are stored; even bits read as zero.
	localparam logic [APM_DATA_W-1:0] APM_SEL_ODD_MASK = 32'haaaaaaaa;
	// Every pin starts on its analog path.
	localparam logic [APM_DATA_W-1:0] APM_SEL_RESET = 32'haaaaaaaa;
	localparam logic [APM_NUM_DIG-1:0] APM_DATA_RESET = 4'h0;
	localparam logic [APM_NUM_DIG-1:0] APM_DIR_RESET = 4'h0;

	// Line numbering of the selection register.
	localparam int APM_LINE_BASE = 16;

	// Line number behind each of the ten pins, order A0 A2 A3 A4 A6 A7
	// B0 B3 B4 B7.
	localparam int APM_PIN_LINE [APM_NUM_PINS] =
		'{16, 18, 19, 20, 22, 23, 24, 27, 28, 31};

	// Lines that really have a digital function, in data bit order.
	localparam int APM_DIG_LINE [APM_NUM_DIG] = '{18, 20, 22, 28};

	// Register request from the processor.
	typedef struct packed {
		logic valid;
		logic write;
		logic from_ctrl_cpu;
		logic [APM_ADDR_W-1:0] addr;
		logic [APM_DATA_W-1:0] wdata;
	} apm_reg_req_t;

	// Register answer to the processor.
	typedef struct packed {
		logic ack;
		logic denied;
		logic [APM_DATA_W-1:0] rdata;
	} apm_reg_rsp_t;

	// Digital drive of the four digital-capable pins.
	typedef struct packed {
		logic [APM_NUM_DIG-1:0] out;
		logic [APM_NUM_DIG-1:0] oe;
	} apm_dig_drive_t;

	// Selection bit index that controls a given line.
	function automatic int apm_sel_idx(input int line);
		apm_sel_idx = 2 * (line - APM_LINE_BASE) + 1;
	endfunction

endpackage

// >>> hdl/apm_in_sync.sv
// Three-stage input synchroniser with agreement filter for pin inputs.
`timescale 1ns/1ps
module apm_in_sync #(
	parameter int WIDTH = 4
) (
	// Clock and reset.
	input wire logic clk,
	input wire logic rst,
	// Raw and filtered levels.
	input wire logic [WIDTH-1:0] raw,
	output logic [WIDTH-1:0] level
);

	logic [WIDTH-1:0] s1_q;
	logic [WIDTH-1:0] s2_q;
	logic [WIDTH-1:0] s3_q;
	logic [WIDTH-1:0] level_q;
	logic [WIDTH-1:0] level_d;
	logic [WIDTH-1:0] agree;

	// The first stage feeds only the second, so it never reaches logic.
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			s1_q <= '0;
			s2_q <= '0;
			s3_q <= '0;
			level_q <= '0;
		end
		else
		begin
			s1_q <= raw;
			s2_q <= s1_q;
			s3_q <= s2_q;
			level_q <= level_d;
		end
	end

	// A new level counts only once the second and third stages agree.
	assign agree = ~(s2_q ^ s3_q);
	assign level_d = (agree & s3_q) | (~agree & level_q);
	assign level = level_q;

endmodule

// >>> hdl/apm_mux.sv
// Analog pin function mux: selection, data and direction registers.
//
// Notes on behaviour
// - After reset every pin is on its analog path, digital disabled.
// - Registers act only on accesses from the control-subsystem CPU; others are refused.
// - Cleared odd selection bit puts A2, A4, A6 or B4 in digital mode; other pins only lose their converter path.
// - Set odd selection bit routes its pin to converter or comparator.
// - Bit 9 switches pin A4 between digital line 20 and analog.
// - Even selection bits have no effect on routing.
// - Only A2, A4, A6, B4 have digital lines 18, 20, 22, 28.
// - Those four pins feed converter and comparator; others converter.
// - Four data bits are readable, writable, each with own direction.
// - Digital lines have no pull-up control.
// - Only digital and analog modes exist; modes 1 and 3 absent.
`timescale 1ns/1ps
module apm_mux
	import apm_pkg::*;
(
	// Clock and reset.
	input wire logic clk,
	input wire logic rst,
	// Register port from the processor.
	input apm_pkg::apm_reg_req_t req,
	output apm_pkg::apm_reg_rsp_t rsp,
	// Digital side of the four digital-capable pins.
	input wire logic [apm_pkg::APM_NUM_DIG-1:0] dig_pin_in,
	output apm_pkg::apm_dig_drive_t dig_drive,
	// Analog routing of the ten pins.
	output logic [apm_pkg::APM_NUM_PINS-1:0] conv_path_en,
	output logic [apm_pkg::APM_NUM_DIG-1:0] comp_path_en
);

	import apm_pkg::*;

	logic [APM_DATA_W-1:0] sel_q;
	logic [APM_DATA_W-1:0] sel_d;
	logic [APM_NUM_DIG-1:0] data_q;
	logic [APM_NUM_DIG-1:0] data_d;
	logic [APM_NUM_DIG-1:0] dir_q;
	logic [APM_NUM_DIG-1:0] dir_d;
	apm_reg_rsp_t rsp_q;
	apm_reg_rsp_t rsp_d;
	logic first_q;

	wire logic [APM_NUM_DIG-1:0] pin_level;
	wire logic [APM_NUM_DIG-1:0] dig_mode;
	wire logic [APM_NUM_DIG-1:0] read_back;
	wire logic granted;
	wire logic denied;
	wire logic wr_sel;
	wire logic wr_data;
	wire logic wr_dir;
	wire logic hit_sel;
	wire logic hit_data;
	wire logic hit_dir;
	wire logic [APM_DATA_W-1:0] rd_word;

	// Pin inputs come from outside the clock domain.
	apm_in_sync #(
		.WIDTH(APM_NUM_DIG)
	) u_sync (
		.clk(clk),
		.rst(rst),
		.raw(dig_pin_in),
		.level(pin_level)
	);

	// Accesses from any other master are turned away here.
	// master filter
	assign granted = req.valid && req.from_ctrl_cpu;
	assign denied = req.valid && !req.from_ctrl_cpu;

	// Address decode; unmapped offsets read zero and ignore writes.
	assign hit_sel = (req.addr == APM_OFS_SELECT);
	assign hit_data = (req.addr == APM_OFS_DATA);
	assign hit_dir = (req.addr == APM_OFS_DIR);
	assign wr_sel = granted && req.write && hit_sel;
	assign wr_data = granted && req.write && hit_data;
	assign wr_dir = granted && req.write && hit_dir;

	// Even bits are dropped on write, so they can never steer a pin.
	// even bits ignored
	assign sel_d = wr_sel ? (req.wdata & APM_SEL_ODD_MASK) : sel_q;
	assign data_d = wr_data ? req.wdata[APM_NUM_DIG-1:0] : data_q;
	assign dir_d = wr_dir ? req.wdata[APM_NUM_DIG-1:0] : dir_q;

	// One bit per pin gives exactly two modes, digital and analog.
	// two modes only
	genvar gi;
	generate
		for (gi = 0; gi < APM_NUM_DIG; gi++)
		begin : g_dig
			assign dig_mode[gi] = !sel_q[apm_sel_idx(APM_DIG_LINE[gi])];
			assign comp_path_en[gi] = !dig_mode[gi];
			// Read returns the pin in input mode, the latch when driving.
			assign read_back[gi] = dig_mode[gi] &&
				(dir_q[gi] ? data_q[gi] : pin_level[gi]);
		end
		for (gi = 0; gi < APM_NUM_PINS; gi++)
		begin : g_pin
			assign conv_path_en[gi] = sel_q[apm_sel_idx(APM_PIN_LINE[gi])];
		end
	endgenerate

	// Pins drive only in digital mode with direction set to output.
	// There is no pull-up output at all; the pad has none to steer.
	// no pull control
	assign dig_drive.oe = dig_mode & dir_q;
	assign dig_drive.out = data_q;

	// Read data selection.
	assign rd_word = hit_sel ? sel_q :
		hit_data ? {{(APM_DATA_W-APM_NUM_DIG){1'b0}}, read_back} :
		hit_dir ? {{(APM_DATA_W-APM_NUM_DIG){1'b0}}, dir_q} :
		{APM_DATA_W{1'b0}};

	// Answer one cycle after the request; refused reads return zero.
	always_comb
	begin
		rsp_d.ack = req.valid;
		rsp_d.denied = denied;
		rsp_d.rdata = (granted && !req.write) ? rd_word : '0;
	end

	// Register state.
	// analog at reset
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			sel_q <= APM_SEL_RESET;
			data_q <= APM_DATA_RESET;
			dir_q <= APM_DIR_RESET;
			rsp_q <= '0;
			first_q <= 1'b1;
		end
		else
		begin
			sel_q <= sel_d;
			data_q <= data_d;
			dir_q <= dir_d;
			rsp_q <= rsp_d;
			first_q <= 1'b0;
		end
	end

	assign rsp = rsp_q;

	// First cycle out of reset shows every pin analog, nothing driven.
	property p_reset_analog;
		@(posedge clk) disable iff (rst)
		first_q |-> (&conv_path_en) && (&comp_path_en) &&
			(dig_drive.oe == '0);
	endproperty
	a_reset_analog: assert property (p_reset_analog)
		else $error("pins not analog after reset");

	// A foreign master changes nothing and reads zero.
	property p_denied_write;
		@(posedge clk) disable iff (rst)
		denied |=> $stable(sel_q) && $stable(data_q) && $stable(dir_q) &&
			rsp.ack && rsp.denied && (rsp.rdata == '0);
	endproperty
	a_denied_write: assert property (p_denied_write)
		else $error("foreign master access took effect");

	// Digital mode isolates the analog paths and follows direction.
	property p_digital_mode;
		@(posedge clk) disable iff (rst)
		!sel_q[5] |-> !conv_path_en[1] && !comp_path_en[0] &&
			(dig_drive.oe[0] == dir_q[0]);
	endproperty
	a_digital_mode: assert property (p_digital_mode)
		else $error("digital mode routing wrong on line 18");

	// Analog mode feeds both destinations and never drives.
	property p_analog_mode;
		@(posedge clk) disable iff (rst)
		sel_q[25] |-> conv_path_en[8] && comp_path_en[3] &&
			!dig_drive.oe[3];
	endproperty
	a_analog_mode: assert property (p_analog_mode)
		else $error("analog mode routing wrong on line 28");

	// Writing bit 9 moves pin A4 on the next cycle.
	property p_bit_nine;
		@(posedge clk) disable iff (rst)
		wr_sel |=> (conv_path_en[3] == $past(req.wdata[9])) &&
			(comp_path_en[1] == $past(req.wdata[9]));
	endproperty
	a_bit_nine: assert property (p_bit_nine)
		else $error("bit 9 did not steer pin A4");

	// Stored selection never holds an even bit.
	property p_even_ignored;
		@(posedge clk) disable iff (rst)
		wr_sel |=> (sel_q == ($past(req.wdata) & APM_SEL_ODD_MASK));
	endproperty
	a_even_ignored: assert property (p_even_ignored)
		else $error("even selection bits were stored");

	// Clearing a reserved pin's bit cuts only that pin's converter path.
	property p_reserved_pins;
		@(posedge clk) disable iff (rst)
		!sel_q[1] |-> !conv_path_en[0] &&
			(conv_path_en[9:1] == {sel_q[31], sel_q[25], sel_q[23],
			sel_q[17], sel_q[15], sel_q[13], sel_q[9], sel_q[7], sel_q[5]});
	endproperty
	a_reserved_pins: assert property (p_reserved_pins)
		else $error("reserved pin gained a function");

	// Comparator enables track the four digital-capable pins' converter.
	property p_comp_pairs;
		@(posedge clk) disable iff (rst)
		comp_path_en == {conv_path_en[8], conv_path_en[4], conv_path_en[3],
			conv_path_en[1]};
	endproperty
	a_comp_pairs: assert property (p_comp_pairs)
		else $error("comparator path not paired with its pin");

	// Written data appears on the drive latch one cycle later.
	property p_data_write;
		@(posedge clk) disable iff (rst)
		wr_data |=> (dig_drive.out == $past(req.wdata[APM_NUM_DIG-1:0]));
	endproperty
	a_data_write: assert property (p_data_write)
		else $error("data write not seen on drive latch");

	// Every request is answered on the next edge, refusals flagged.
	property p_ack_follows;
		@(posedge clk) disable iff (rst)
		req.valid |=> rsp.ack && (rsp.denied == !$past(req.from_ctrl_cpu));
	endproperty
	a_ack_follows: assert property (p_ack_follows)
		else $error("request not answered on the next edge");

	// No answer shows without a request behind it.
	property p_ack_quiet;
		@(posedge clk) disable iff (rst)
		!req.valid |=> !rsp.ack && !rsp.denied && (rsp.rdata == '0);
	endproperty
	a_ack_quiet: assert property (p_ack_quiet)
		else $error("answer seen without a request");

	// Unmapped offsets change nothing and read zero.
	property p_unmapped;
		@(posedge clk) disable iff (rst)
		req.valid && !hit_sel && !hit_data && !hit_dir |=>
			(rsp.rdata == '0) && $stable(sel_q) && $stable(data_q) &&
			$stable(dir_q);
	endproperty
	a_unmapped: assert property (p_unmapped)
		else $error("unmapped access had an effect");

	// A granted write answers with zero data and no refusal.
	property p_write_quiet;
		@(posedge clk) disable iff (rst)
		granted && req.write |=> !rsp.denied && (rsp.rdata == '0);
	endproperty
	a_write_quiet: assert property (p_write_quiet)
		else $error("granted write answered wrongly");

	// Selection reads give back the stored odd bits, even bits as zero.
	property p_sel_readback;
		@(posedge clk) disable iff (rst)
		granted && !req.write && hit_sel |=>
			(rsp.rdata == $past(sel_q)) &&
			((rsp.rdata & ~APM_SEL_ODD_MASK) == '0);
	endproperty
	a_sel_readback: assert property (p_sel_readback)
		else $error("selection read back wrong");

	// Each digital line follows its own odd bit: 5, 9, 13 and 25.
	property p_line_bits;
		@(posedge clk) disable iff (rst)
		comp_path_en == {sel_q[25], sel_q[13], sel_q[9], sel_q[5]};
	endproperty
	a_line_bits: assert property (p_line_bits)
		else $error("digital line not steered by its odd bit");

	// A direction write reaches the pad enables one cycle later.
	property p_dir_write;
		@(posedge clk) disable iff (rst)
		wr_dir |=> dig_drive.oe ==
			($past(req.wdata[APM_NUM_DIG-1:0]) & ~comp_path_en);
	endproperty
	a_dir_write: assert property (p_dir_write)
		else $error("direction write not seen on pad enables");

	// Data reads give the latch when driving, the pad when sampling.
	property p_data_read;
		@(posedge clk) disable iff (rst)
		granted && !req.write && hit_data |=>
			(rsp.rdata[APM_DATA_W-1:APM_NUM_DIG] == '0) &&
			(rsp.rdata[APM_NUM_DIG-1:0] == $past(~comp_path_en &
			((dir_q & data_q) | (~dir_q & pin_level))));
	endproperty
	a_data_read: assert property (p_data_read)
		else $error("data read returned wrong bits");

	// A pin routed to the analog side is never driven as well.
	property p_analog_quiet;
		@(posedge clk) disable iff (rst)
		(dig_drive.oe & comp_path_en) == '0;
	endproperty
	a_analog_quiet: assert property (p_analog_quiet)
		else $error("pin driven while in analog mode");

	// The drive latch also starts cleared, with no answer pending.
	property p_reset_latch;
		@(posedge clk) disable iff (rst)
		first_q |-> (dig_drive.out == APM_DATA_RESET) && !rsp.ack;
	endproperty
	a_reset_latch: assert property (p_reset_latch)
		else $error("drive latch not cleared after reset");

endmodule

// >>> tb/apm_cpu_model.sv
// Behavioural control-subsystem processor issuing register requests.
`timescale 1ns/1ps
module apm_cpu_model (
	// Clock.
	input wire logic clk,
	// Request toward the mux.
	output apm_pkg::apm_reg_req_t req
);
	import apm_pkg::*;

	// Idle cycles before each request, so slow software can be mimicked.
	int gap = 0;

	initial
		req = '0;

	// both analog destinations
	// The analog peripherals are never touched here; in analog mode both
	// destinations of a shared pin are enabled together.
	task automatic access(input logic w, c, input logic [7:0] a,
		input logic [31:0] d);
		repeat (gap) @(negedge clk);
		@(negedge clk);
		req <= '{1'b1, w, c, a, d};
		@(negedge clk);
		req.valid <= 1'b0;
		// Released lines must not look like a held request.
		req.addr <= ~a;
		req.wdata <= ~d;
	endtask
endmodule

// >>> tb/analog_pin_function_mux_bench.sv
// Self-checking bench for the analog pin function mux.
`timescale 1ns/1ps
module analog_pin_function_mux_bench;
	import apm_pkg::*;

	logic clk;
	logic rst;
	logic [3:0] dig_pin_in;
	apm_reg_req_t req;
	apm_reg_rsp_t rsp;
	apm_dig_drive_t dig_drive;
	logic [9:0] conv_path_en;
	logic [3:0] comp_path_en;
	logic [32:0] exp_q[$];
	int failures = 0;
	int total_checks = 0;
	int cycles = 0;
	int seed = 77;
	int pin_of [4] = '{1, 3, 4, 8};
	logic [31:0] r;
	logic [31:0] sel;

	apm_mux apm_mux_inst (.clk(clk), .rst(rst), .req(req), .rsp(rsp),
		.dig_pin_in(dig_pin_in), .dig_drive(dig_drive),
		.conv_path_en(conv_path_en), .comp_path_en(comp_path_en));
	apm_cpu_model apm_cpu_model_inst (.clk(clk), .req(req));

	// Clock of 4 ns.
	initial
	begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	task automatic check(input logic [32:0] seen, input logic [32:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			failures++;
			$display("unexpected at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask

	// Issue an access and note the answer it should bring.
	task automatic acc(input logic w, c, input logic [7:0] a,
		input logic [31:0] d, input logic [32:0] e);
		exp_q.push_back(e);
		apm_cpu_model_inst.access(w, c, a, d);
	endtask

	task automatic finish_test();
		$display("checks %0d failures %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// Answers are sampled mid-cycle, where the registered pulse is settled.
	always @(negedge clk)
		if (rsp.ack === 1'b1)
		begin
			if (exp_q.size() == 0)
				check(33'h1ffffffff, 33'h0);
			else
				check({rsp.denied, rsp.rdata}, exp_q.pop_front());
		end

	// A hang is cut short well past the expected run length.
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 3000)
		begin
			failures++;
			finish_test();
		end
	end

	initial
	begin
		rst = 1'b1;
		dig_pin_in = 4'h0;
		repeat (2) @(posedge clk);
		@(negedge clk);
		rst = 1'b0;
		check({23'h0, conv_path_en}, 33'h3ff);
		check({29'h0, comp_path_en}, 33'hf);
		check({25'h0, dig_drive}, 33'h0);
		acc(0, 1, APM_OFS_SELECT, 0, {1'b0, APM_SEL_RESET});
		acc(0, 1, APM_OFS_DIR, 0, 33'h0);
		// one line digital, junk in even bits
		for (int i = 0; i < 4; i++)
		begin
			sel = 32'haaaaaaaa & ~(32'h1 << (2 * (APM_DIG_LINE[i] - 16) + 1));
			r = $random(seed);
			acc(1, 1, APM_OFS_SELECT, sel | (r & 32'h55555555), 33'h0);
			acc(0, 1, APM_OFS_SELECT, 0, {1'b0, sel});
			// Index 1 is bit 9 for line 20.
			check({23'h0, conv_path_en},
				{23'h0, 10'h3ff ^ 10'(10'h1 << pin_of[i])});
			check({29'h0, comp_path_en},
				{29'h0, 4'hf ^ 4'(4'h1 << i)});
		end
		acc(1, 1, APM_OFS_SELECT, 32'haaaaaaa8, 33'h0);
		check({23'h0, conv_path_en}, 33'h3fe);
		check({29'h0, comp_path_en}, 33'hf);
		sel = 32'haaaaaaaa & ~32'h02002220;
		r = $random(seed);
		acc(1, 1, APM_OFS_SELECT, sel, 33'h0);
		acc(1, 1, APM_OFS_DIR, 32'hf, 33'h0);
		acc(1, 1, APM_OFS_DATA, r, 33'h0);
		acc(0, 1, APM_OFS_DATA, 0, {29'h0, r[3:0]});
		check({25'h0, dig_drive}, {25'h0, r[3:0], 4'hf});
		dig_pin_in = r[7:4];
		acc(1, 1, APM_OFS_DIR, 32'h5, 33'h0);
		// Pin levels need a few cycles to pass the input filter.
		repeat (6) @(negedge clk);
		acc(0, 1, APM_OFS_DATA, 0,
			{29'h0, (r[3:0] & 4'h5) | (r[7:4] & 4'ha)});
		check({29'h0, dig_drive.oe}, 33'h5);
		apm_cpu_model_inst.gap = 3;
		acc(1, 0, APM_OFS_SELECT, 32'hffffffff, {1'b1, 32'h0});
		acc(0, 0, APM_OFS_SELECT, 0, {1'b1, 32'h0});
		apm_cpu_model_inst.gap = 0;
		acc(0, 1, APM_OFS_SELECT, 0, {1'b0, sel});
		acc(0, 1, 8'h0c, 0, 33'h0);
		acc(1, 1, APM_OFS_SELECT, 32'hffffffff, 33'h0);
		acc(0, 1, APM_OFS_SELECT, 0, {1'b0, APM_SEL_RESET});
		acc(0, 1, APM_OFS_DATA, 0, 33'h0);
		check({29'h0, dig_drive.oe}, 33'h0);
		check({23'h0, conv_path_en}, 33'h3ff);
		check({29'h0, comp_path_en}, 33'hf);
		repeat (3) @(negedge clk);
		check(33'(exp_q.size()), 33'h0);
		finish_test();
	end
endmodule
